// >>> hw/wdh_regs.svh
// Constants of the watchdog, halt and reset-cause block.
// Assumes a 32-bit AXI4-Lite register slave with word-aligned registers.
`ifndef WDH_REGS_SVH
`define WDH_REGS_SVH

`define WDH_ADDR_W          8
`define WDH_OFF_SETTING     8'h00
`define WDH_OFF_STATUS      8'h04
`define WDH_OFF_CONTROL     8'h08
`define WDH_OFF_CAUSE       8'h0C
`define WDH_SETTING_RST     8'h07
`define WDH_PSEL_LSB        0
`define WDH_PSEL_MSB        2
`define WDH_SLEEP_BIT       4
`define WDH_EXPIRY_BIT      5
`define WDH_CTL_HALT_BIT    0
`define WDH_CTL_CLR_BIT     1
`define WDH_CTL_CLR1_BIT    2
`define WDH_CTL_CLR2_BIT    3
`define WDH_INSTR_DIV       4
`define WDH_RC_DIV_W        8
`define WDH_PRESC_W         7
`define WDH_SST_CYCLES      1024
`define WDH_SST_W           11
`define WDH_RESP_OKAY       2'h0
`define WDH_RESP_SLVERR     2'h2

`endif

// >>> hw/wdh_pkg.sv
// Types of the watchdog, halt and reset-cause block.
// Assumes nothing beyond the constants header.
package wdh_pkg;
  typedef enum logic [1:0] {
    WDH_RUN   = 2'b00,
    WDH_HALT  = 2'b01,
    WDH_DELAY = 2'b10
  } wdh_mode_e;
  typedef logic [7:0] wdh_byte_t;
endpackage

// >>> hw/wdh_guard.sv
// Watchdog with prescaler, halt control, wake-up delay and reset-cause flags.
// Assumes the core pulses its instruction strobes for one aclk cycle and that
// rc_tick is a one-cycle pulse synchronous to aclk from the on-chip oscillator.
// Behaviour
// - Counts RC oscillator or instruction clock by option
// - Disabled option makes watchdog operations ineffective
// - RC clock first divided by 256
// - Period select bits give 2^n prescale
// - Setting bits 7..3 are software flags only
// - Instruction clock source stops counting while halted
// - Normal overflow gives chip reset, sets expiry
// - Halted overflow gives warm reset only
// - Reset pin, clear, halt clear counter
// - Option selects single or paired clear
// - Halt keeps state, watchdog restarts counting
// - Halt sets sleep, clears expiry
// - Halt output pin high while halted
// - Wake on reset, interrupt, overflow, port A
// - Sleep cleared at power-up and clear
// - Resume next instruction or take interrupt
// - Wake waits 1024 cycles, interrupt one more
// - Pending interrupt before halt cannot wake
// - Flag pairs per reset cause
// - Start-up delay on power-up and wake only
// - Chip reset puts functional units in reset state
// - Expiry flag in status bit 5
// - Sleep flag in status bit 4
`timescale 1ns/10ps
`default_nettype none
`include "wdh_regs.svh"

module wdh_guard #(
  parameter bit       GUARD_ENABLE = 1'b1,
  parameter bit       USE_RC_CLOCK = 1'b1,
  parameter bit       PAIRED_CLEAR = 1'b0,
  parameter bit [7:0] PA_WAKE_MASK = 8'hFF
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [`WDH_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`WDH_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    power_up,
  input  wire logic                    ext_init_pin_n,
  input  wire logic                    rc_tick,
  input  wire logic                    guard_clear_instr,
  input  wire logic                    guard_clear_first,
  input  wire logic                    guard_clear_second,
  input  wire logic                    halt_instr,
  input  wire logic                    irq_request,
  input  wire logic                    irq_enabled,
  input  wire logic                    stack_full,
  input  wire logic [7:0]              port_a_in,
  output logic                         halt_pin,
  output logic                         sys_clock_run,
  output logic                         core_hold,
  output logic                         chip_reset,
  output logic                         warm_reset,
  output logic                         resume_next,
  output logic                         take_irq,
  output logic                         expiry_flag,
  output logic                         sleep_flag,
  output wdh_pkg::wdh_byte_t           guard_period_setting
);
  import wdh_pkg::*;

  wdh_mode_e                  mode;
  logic [1:0]                 instr_div;
  logic [`WDH_RC_DIV_W-1:0]   rc_div;
  logic [`WDH_PRESC_W-1:0]    presc;
  logic [`WDH_SST_W-1:0]      sst_count;
  logic                       clr1_seen;
  logic                       clr2_seen;
  logic                       irq_masked;
  logic                       irq_pending_d;
  logic [7:0]                 port_a_d;
  logic                       wake_irq;
  logic                       wake_by_irq;
  logic                       irq_tail;
  logic                       sw_halt;
  logic                       sw_clr;
  logic                       sw_clr1;
  logic                       sw_clr2;
  logic                       aw_hold;
  logic                       w_hold;
  logic [`WDH_ADDR_W-1:0]     aw_addr;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;

  logic                       do_halt;
  logic                       clr_single;
  logic                       clr_pair;
  logic                       guard_clear;
  logic                       base_tick;
  logic                       rc_div_wrap;
  logic                       overflow;
  logic                       pa_wake;
  logic                       irq_wake;
  logic                       pin_low;
  logic                       wr_fire;
  logic [`WDH_PRESC_W-1:0]    presc_last;

  // Period select field of a setting byte
  function automatic logic [2:0] period_sel(input logic [7:0] setting);
    period_sel = setting[`WDH_PSEL_MSB:`WDH_PSEL_LSB];
  endfunction

  function automatic logic addr_hit(input logic [`WDH_ADDR_W-1:0] a, input logic [`WDH_ADDR_W-1:0] off);
    addr_hit = (a == off);
  endfunction

  assign pin_low    = !ext_init_pin_n;
  assign do_halt    = (halt_instr || sw_halt) && (mode == WDH_RUN);
  assign clr_single = (guard_clear_instr || sw_clr) && !PAIRED_CLEAR;
  assign clr_pair   = PAIRED_CLEAR && (clr1_seen || guard_clear_first || sw_clr1)
                      && (clr2_seen || guard_clear_second || sw_clr2);
  assign guard_clear = GUARD_ENABLE && (clr_single || clr_pair);

  // Instruction clock is sysclk/4; it halts with the system oscillator
  assign base_tick = USE_RC_CLOCK ? rc_tick
                                  : ((instr_div == 2'(`WDH_INSTR_DIV - 1)) && mode != WDH_HALT);
  assign rc_div_wrap = base_tick && (rc_div == {`WDH_RC_DIV_W{1'b1}});
  assign presc_last  = `WDH_PRESC_W'((1 << period_sel(guard_period_setting)) - 1);
  assign overflow    = GUARD_ENABLE && rc_div_wrap && (presc >= presc_last) && mode != WDH_DELAY;

  assign pa_wake  = |(port_a_d & ~port_a_in & PA_WAKE_MASK);
  assign irq_wake = irq_request && !irq_masked;
  assign wr_fire  = aw_hold && w_hold && !s_axi_bvalid;

  // Instruction clock divider
  always_ff @(posedge aclk) begin
    if (!aresetn || power_up) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  // Watchdog divider and prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn || power_up || pin_low || guard_clear || do_halt || overflow || mode == WDH_DELAY) begin
      rc_div <= '0;
      presc  <= '0;
    end else if (base_tick) begin
      rc_div <= rc_div + `WDH_RC_DIV_W'(1);
      if (rc_div_wrap) begin
        presc <= presc + `WDH_PRESC_W'(1);
      end
    end
  end

  // Paired clear memory
  always_ff @(posedge aclk) begin
    if (!aresetn || power_up || pin_low || guard_clear) begin
      clr1_seen <= 1'b0;
      clr2_seen <= 1'b0;
    end else begin
      if (guard_clear_first || sw_clr1) begin
        clr1_seen <= 1'b1;
      end
      if (guard_clear_second || sw_clr2) begin
        clr2_seen <= 1'b1;
      end
    end
  end

  // Mode sequencing and start-up delay
  always_ff @(posedge aclk) begin
    if (!aresetn || power_up) begin
      mode        <= WDH_DELAY;
      sst_count   <= `WDH_SST_W'(`WDH_SST_CYCLES);
      wake_by_irq <= 1'b0;
    end else if (pin_low) begin
      mode        <= WDH_RUN;
      sst_count   <= '0;
      wake_by_irq <= 1'b0;
    end else begin
      unique case (mode)
        WDH_RUN: begin
          if (do_halt) begin
            mode <= WDH_HALT;
          end
        end
        WDH_HALT: begin
          if (overflow || pa_wake || irq_wake) begin
            mode        <= WDH_DELAY;
            sst_count   <= `WDH_SST_W'(`WDH_SST_CYCLES);
            wake_by_irq <= irq_wake && !overflow;
          end
        end
        WDH_DELAY: begin
          if (sst_count <= `WDH_SST_W'(1)) begin
            mode <= WDH_RUN;
          end
          sst_count <= sst_count - `WDH_SST_W'(1);
        end
        default: begin
          mode <= WDH_RUN;
        end
      endcase
    end
  end

  // Interrupt pending at halt entry loses its wake right
  always_ff @(posedge aclk) begin
    if (!aresetn || power_up) begin
      irq_masked    <= 1'b0;
      irq_pending_d <= 1'b0;
    end else begin
      irq_pending_d <= irq_request;
      if (do_halt) begin
        irq_masked <= irq_request;
      end else if (!irq_request && irq_pending_d) begin
        irq_masked <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_d <= 8'hFF;
    end else begin
      port_a_d <= port_a_in;
    end
  end

  // Flags: power-up wins, then pin reset, then events
  always_ff @(posedge aclk) begin
    if (!aresetn || power_up) begin
      expiry_flag <= 1'b0;
      sleep_flag  <= 1'b0;
    end else if (pin_low) begin
      if (mode == WDH_HALT) begin
        expiry_flag <= 1'b0;
        sleep_flag  <= 1'b1;
      end
    end else if (overflow) begin
      expiry_flag <= 1'b1;
      if (mode == WDH_HALT) begin
        sleep_flag <= 1'b1;
      end
    end else if (do_halt) begin
      sleep_flag  <= 1'b1;
      expiry_flag <= 1'b0;
    end else if (guard_clear) begin
      sleep_flag  <= 1'b0;
      expiry_flag <= 1'b0;
    end
  end

  // Core-facing strobes and levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_pin      <= 1'b0;
      sys_clock_run <= 1'b0;
      core_hold     <= 1'b1;
      chip_reset    <= 1'b1;
      warm_reset    <= 1'b0;
      resume_next   <= 1'b0;
      take_irq      <= 1'b0;
      irq_tail      <= 1'b0;
    end else begin
      halt_pin      <= ((mode == WDH_HALT) || do_halt) && !pin_low && !power_up;
      sys_clock_run <= !((mode == WDH_HALT) || do_halt) || pin_low || power_up;
      core_hold     <= (mode != WDH_RUN) || do_halt;
      // Warm reset keeps everything but PC and SP
      chip_reset    <= power_up || pin_low || (overflow && mode == WDH_RUN);
      warm_reset    <= overflow && mode == WDH_HALT;
      irq_tail      <= 1'b0;
      resume_next   <= 1'b0;
      take_irq      <= irq_tail;
      if (mode == WDH_DELAY && sst_count == `WDH_SST_W'(1) && !pin_low) begin
        if (wake_by_irq && irq_enabled && !stack_full) begin
          irq_tail <= 1'b1;
        end else begin
          resume_next <= 1'b1;
        end
      end
    end
  end

  // Setting register; bits 7..3 are stored only
  always_ff @(posedge aclk) begin
    if (!aresetn || power_up || chip_reset) begin
      guard_period_setting <= `WDH_SETTING_RST;
    end else if (wr_fire && addr_hit(aw_addr, `WDH_OFF_SETTING) && w_strb[0]) begin
      guard_period_setting <= w_data[7:0];
    end
  end

  // AXI write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `WDH_RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      sw_halt      <= 1'b0;
      sw_clr       <= 1'b0;
      sw_clr1      <= 1'b0;
      sw_clr2      <= 1'b0;
    end else begin
      sw_halt <= 1'b0;
      sw_clr  <= 1'b0;
      sw_clr1 <= 1'b0;
      sw_clr2 <= 1'b0;
      s_axi_awready <= !(aw_hold || (s_axi_awvalid && s_axi_awready) || wr_fire || (s_axi_bvalid && !s_axi_bready));
      s_axi_wready  <= !(w_hold || (s_axi_wvalid && s_axi_wready) || wr_fire || (s_axi_bvalid && !s_axi_bready));
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `WDH_RESP_OKAY;
        if (addr_hit(aw_addr, `WDH_OFF_CONTROL) && w_strb[0]) begin
          sw_halt <= w_data[`WDH_CTL_HALT_BIT];
          sw_clr  <= w_data[`WDH_CTL_CLR_BIT];
          sw_clr1 <= w_data[`WDH_CTL_CLR1_BIT];
          sw_clr2 <= w_data[`WDH_CTL_CLR2_BIT];
        end else if (!addr_hit(aw_addr, `WDH_OFF_SETTING)) begin
          s_axi_bresp <= `WDH_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `WDH_RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `WDH_RESP_OKAY;
        s_axi_rdata  <= '0;
        if (addr_hit(s_axi_araddr, `WDH_OFF_SETTING)) begin
          s_axi_rdata[7:0] <= guard_period_setting;
        end else if (addr_hit(s_axi_araddr, `WDH_OFF_STATUS)) begin
          s_axi_rdata[`WDH_EXPIRY_BIT] <= expiry_flag;
          s_axi_rdata[`WDH_SLEEP_BIT]  <= sleep_flag;
        end else if (addr_hit(s_axi_araddr, `WDH_OFF_CAUSE)) begin
          s_axi_rdata[1:0] <= mode;
        end else if (!addr_hit(s_axi_araddr, `WDH_OFF_CONTROL)) begin
          s_axi_rresp <= `WDH_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // wdh_guard

`default_nettype wire

// >>> test/wdh_core_model.sv
// Core model: issues clear and halt instruction strobes on request.
// Assumes one-cycle requests from the bench, none while the core is held.
`timescale 1ns/10ps
`default_nettype none
module wdh_core_model (
  input  wire logic       aclk,
  input  wire logic       core_hold,
  input  wire logic [2:0] cmd,
  input  wire logic       cmd_go,
  output logic            guard_clear_instr,
  output logic            guard_clear_first,
  output logic            guard_clear_second,
  output logic            halt_instr
);
  initial begin
    {guard_clear_instr, guard_clear_first, guard_clear_second, halt_instr} = 4'h0;
  end
  // A held core issues nothing; the real core is stalled then
  always @(posedge aclk) begin
    guard_clear_instr  <= cmd_go && !core_hold && cmd == 3'h1;
    guard_clear_first  <= cmd_go && !core_hold && cmd == 3'h2;
    guard_clear_second <= cmd_go && !core_hold && cmd == 3'h3;
    halt_instr         <= cmd_go && !core_hold && cmd == 3'h4;
  end
endmodule // wdh_core_model
`default_nettype wire

// >>> test/wdh_guard_checker.sv
// Assertions on the ports of the watchdog, halt and reset-cause block.
// Assumes it is bound to wdh_guard with one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "wdh_regs.svh"
module wdh_guard_checker #(
  parameter bit PAIRED_CLEAR = 1'b0
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               power_up,
  input wire logic               ext_init_pin_n,
  input wire logic               guard_clear_instr,
  input wire logic               halt_instr,
  input wire logic               irq_enabled,
  input wire logic               stack_full,
  input wire logic               halt_pin,
  input wire logic               sys_clock_run,
  input wire logic               core_hold,
  input wire logic               chip_reset,
  input wire logic               warm_reset,
  input wire logic               resume_next,
  input wire logic               take_irq,
  input wire logic               expiry_flag,
  input wire logic               sleep_flag,
  input wire wdh_pkg::wdh_byte_t guard_period_setting
);
  import wdh_pkg::*;
  logic        armed;
  logic [15:0] wake_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since leaving halt; a pin reset disarms, as it skips the delay
  always_ff @(posedge aclk) begin
    if (!aresetn || chip_reset || resume_next || take_irq) begin
      armed <= 1'b0;
    end else if ($fell(halt_pin)) begin
      armed <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    wake_cnt <= $fell(halt_pin) ? 16'h0001 : wake_cnt + 16'h0001;
  end
  sequence s_entered;
    $past(halt_instr) && sleep_flag && !expiry_flag;
  endsequence
  sequence s_halted;
    !sys_clock_run && core_hold;
  endsequence
  property p_halt_entry;
    $rose(halt_pin) |-> s_entered;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("halt entry wrong");
  property p_halted;
    halt_pin |-> s_halted;
  endproperty
  a_halted: assert property (p_halted) else $error("clock runs while halted");
  property p_warm;
    warm_reset |=> expiry_flag && sleep_flag && !chip_reset;
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset flags wrong");
  property p_overflow;
    $rose(expiry_flag) |-> ##[0:2] (chip_reset || warm_reset);
  endproperty
  a_overflow: assert property (p_overflow) else $error("expiry without reset");
  property p_setting;
    chip_reset |-> ##[0:1] (guard_period_setting == `WDH_SETTING_RST);
  endproperty
  a_setting: assert property (p_setting) else $error("setting not reset");
  property p_pin;
    !ext_init_pin_n |=> chip_reset && !halt_pin;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset ignored");
  property p_clear;
    !PAIRED_CLEAR && guard_clear_instr && ext_init_pin_n && !power_up && !halt_instr && !core_hold |=> !sleep_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left sleep set");
  property p_irq;
    take_irq |-> irq_enabled && !stack_full;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt taken wrongly");
  property p_wake;
    armed && (resume_next || take_irq) |-> wake_cnt >= 16'h03FE && wake_cnt <= 16'h0404;
  endproperty
  a_wake: assert property (p_wake) else $error("wake delay wrong");
endmodule // wdh_guard_checker
`default_nettype wire

// >>> test/wdh_guard_tb_top.sv
// Testbench: AXI4-Lite accesses and core instructions against the guard.
// Assumes the core model and the checker are compiled beforehand.
`timescale 1ns/10ps
`default_nettype none
`include "wdh_regs.svh"
module wdh_guard_tb_top;
  import wdh_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, power_up = 1'b1, ext_init_pin_n = 1'b1, rc_tick = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, port_a_in = 8'hFF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        irq_request = 1'b0, irq_enabled = 1'b1, stack_full = 1'b0, cmd_go = 1'b0;
  logic        guard_clear_instr, guard_clear_first, guard_clear_second, halt_instr;
  logic        halt_pin, sys_clock_run, core_hold, chip_reset, warm_reset, resume_next, take_irq;
  logic        expiry_flag, sleep_flag;
  wdh_byte_t   guard_period_setting;
  logic [2:0]  cmd = 3'h0;
  int          n_errors = 0, checks = 0, cyc = 0, n;
  wdh_guard #(.PA_WAKE_MASK(8'h01)) i_wdh_guard (.*);
  wdh_core_model i_wdh_core_model (.*);
  always #10 aclk = ~aclk;
  // Whole run is about 6600 cycles; a hang stops here
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is sampled mid-cycle, before the edge that takes it
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    logic pa = 1'b1;
    logic pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end while (pa || pw);
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic instr(input logic [2:0] c);
    @(posedge aclk);
    cmd    <= c;
    cmd_go <= 1'b1;
    @(posedge aclk);
    cmd_go <= 1'b0;
    @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (s !== v && n < lim);
    chk(s, v);
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn  <= 1'b1;
    power_up <= 1'b0;
    wait_lvl(core_hold, 1'b0, 1100);
    chk(n >= 1020, 1'b1);
    axr(`WDH_OFF_SETTING);
    chk(rd, 32'h07);
    axr(`WDH_OFF_STATUS);
    chk(rd, 32'h00);
    axr(8'h10);
    chk(rsp, `WDH_RESP_SLVERR);
    instr(3'h1);
    axw(`WDH_OFF_SETTING, 32'hF8);
    chk(rsp, `WDH_RESP_OKAY);
    instr(3'h1);
    axr(`WDH_OFF_SETTING);
    chk(rd, 32'hF8);
    chk(guard_period_setting, 8'hF8);
    repeat (4) begin
      settle(200);
      instr(3'h1);
    end
    chk(expiry_flag, 1'b0);
    instr(3'h2);
    instr(3'h3);
    $display("test clear done");
    wait_lvl(chip_reset, 1'b1, 400);
    chk({expiry_flag, sleep_flag}, 2'b10);
    wait_lvl(core_hold, 1'b0, 1200);
    axr(`WDH_OFF_SETTING);
    chk(rd, 32'h07);
    $display("test overflow done");
    instr(3'h4);
    chk({halt_pin, sys_clock_run}, 2'b10);
    chk({expiry_flag, sleep_flag}, 2'b01);
    axr(`WDH_OFF_STATUS);
    chk(rd, 32'h10);
    axr(`WDH_OFF_CAUSE);
    chk(rd, 32'h01);
    port_a_in <= 8'hFD;
    settle(20);
    chk(halt_pin, 1'b1);
    @(posedge aclk);
    port_a_in <= 8'hFC;
    wait_lvl(resume_next, 1'b1, 1200);
    chk(n >= 1020 && n <= 1030, 1'b1);
    @(posedge aclk);
    port_a_in <= 8'hFF;
    instr(3'h1);
    chk(sleep_flag, 1'b0);
    $display("test port wake done");
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      stack_full <= k[0];
      instr(3'h4);
      @(posedge aclk);
      irq_request <= 1'b1;
      if (k == 0) wait_lvl(take_irq, 1'b1, 1200);
      else wait_lvl(resume_next, 1'b1, 1200);
      @(posedge aclk);
      irq_request <= 1'b0;
    end
    $display("test irq wake done");
    @(posedge aclk);
    irq_request <= 1'b1;
    instr(3'h4);
    settle(30);
    chk(halt_pin, 1'b1);
    @(posedge aclk);
    ext_init_pin_n <= 1'b0;
    settle(2);
    @(posedge aclk);
    ext_init_pin_n <= 1'b1;
    irq_request    <= 1'b0;
    settle(1);
    chk({expiry_flag, sleep_flag, guard_period_setting}, {2'b01, 8'h07});
    wait_lvl(core_hold, 1'b0, 20);
    axw(`WDH_OFF_CONTROL, 32'h02);
    chk(rsp, `WDH_RESP_OKAY);
    axr(`WDH_OFF_STATUS);
    chk(rd, 32'h00);
    $display("test pin reset done");
    axw(`WDH_OFF_SETTING, 32'h00);
    instr(3'h4);
    wait_lvl(warm_reset, 1'b1, 400);
    chk({expiry_flag, sleep_flag, guard_period_setting}, {2'b11, 8'h00});
    wait_lvl(resume_next, 1'b1, 1200);
    chk(n >= 1015 && n <= 1030, 1'b1);
    $display("test warm wake done");
    end_of_test();
  end
endmodule // wdh_guard_tb_top
bind wdh_guard wdh_guard_checker #(.PAIRED_CLEAR(PAIRED_CLEAR)) i_wdh_guard_checker (.*);
`default_nettype wire
